// ### verilog/fp_lazy_stacking_exception_unit.sv
// Exception entry/return sequencer with lazy FP stacking and write buffer.
// Assumes interrupt sources and the core run on mclk_in; memory is a
// waitrequest-style master port; registers sit on an Avalon-MM slave.
`timescale 1ns/1ps

module fp_lazy_stacking_exception_unit
  import fp_exc_pkg::*;
(
  input  wire logic                 mclk_in,            // Core clock, 10 MHz
  input  wire logic                 nrst_in,            // Sync reset, active low
  input  wire logic [31:0]          avs_address_in,     // Register byte address
  input  wire logic                 avs_read_in,        // Register read
  input  wire logic                 avs_write_in,       // Register write
  input  wire logic [31:0]          avs_writedata_in,   // Register write data
  input  wire logic [3:0]           avs_byteenable_in,  // Write byte lanes
  output logic [31:0]               avs_readdata_out,   // Register read data
  output logic                      avs_waitrequest_out, // Slave stall
  input  wire logic [NUM_IRQ-1:0]   irq_src_in,         // Level interrupt sources
  output logic                      irq_ack_out,        // Interrupt acknowledge
  output logic [IRQ_W-1:0]          ack_num_out,        // Acknowledged number
  output logic                      vector_fetch_out,   // Vector fetch strobe
  output logic [IRQ_W-1:0]          vector_num_out,     // Fetched vector number
  output logic                      handler_start_out,  // First handler cycle
  output logic                      core_stall_out,     // Core must hold
  input  wire logic                 fp_instr_in,        // Handler FP instruction
  input  wire logic                 exc_return_in,      // branch_exchange_return
  input  wire logic                 barrier_in,         // Data sync barrier
  input  wire logic                 store_valid_in,     // Store request
  input  wire logic [31:0]          store_addr_in,      // Store address
  input  wire logic [31:0]          store_data_in,      // Store data
  output logic                      store_ready_out,    // Store buffer free
  input  wire logic                 div_issue_in,       // Divide or root issue
  input  wire logic [REG_IDX_W-1:0] div_dest_in,        // Divide destination
  input  wire logic [31:0]          div_result_in,      // Divide result
  input  wire logic [FLAG_W-1:0]    div_flags_in,       // Divide flags
  output logic                      rf_we_out,          // Register write strobe
  output logic [REG_IDX_W-1:0]      rf_waddr_out,       // Register write index
  output logic [31:0]               rf_wdata_out,       // Register write data
  output logic                      fp_status_control_reg_we_out,       // Status flag strobe
  output logic [FLAG_W-1:0]         fp_status_control_reg_flags_out,    // Status flags
  output logic                      mem_write_out,      // Memory write request
  output logic                      mem_read_out,       // Memory read request
  output logic [31:0]               mem_addr_out,       // Memory address
  output logic [31:0]               mem_wdata_out,      // Memory write data
  input  wire logic                 mem_waitrequest_in  // Memory stall
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic reg_sel_t reg_decode(input logic [31:0] addr);
    reg_decode = (addr == FP_CTX_CTRL_ADDR) ? RSEL_FP_CTX :
                 (addr == AUX_CTRL_ADDR)    ? RSEL_AUX :
                 (addr == EXC_STATUS_ADDR)  ? RSEL_STATUS : RSEL_NONE;
  endfunction

  function automatic logic [IRQ_W-1:0] top_pending(input logic [NUM_IRQ-1:0] p);
    top_pending = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
      if (p[i])
        top_pending = IRQ_W'(i);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and storage

  exc_state_t           state;
  exc_state_t           next_state;
  logic [NUM_IRQ-1:0]   pending;
  logic                 fp_lazy_save_enable;
  logic                 wbuf_dis;
  logic                 lazy_active;
  logic                 fp_in_frame;
  logic [CNT_W-1:0]     xfer_cnt;
  logic [CNT_W-1:0]     stk_cyc;
  logic [CNT_W-1:0]     ack_age;
  logic                 mem_is_store;
  logic                 wbuf_valid;
  logic [31:0]          wbuf_addr;
  logic [31:0]          wbuf_data;
  logic                 div_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational decode

  wire any_pend  = |pending;
  wire [IRQ_W-1:0] top_num = top_pending(pending);
  wire lazy_pend = lazy_active & ~fp_in_frame;
  wire mem_busy  = mem_write_out | mem_read_out;
  wire mem_done  = mem_busy & ~mem_waitrequest_in;
  wire in_xfer   = (state == STACKING) | (state == LAZY_PUSH) | (state == UNSTACKING);

  wire [CNT_W-1:0] xfer_target = (state == LAZY_PUSH) ? FP_WORDS :
                                 fp_in_frame ? ALL_WORDS : CORE_WORDS;
  wire [CNT_W-1:0] xfer_off    = (state == LAZY_PUSH) ? CORE_WORDS : '0;
  wire [CNT_W-1:0] xfer_idx    = xfer_off + xfer_cnt;
  wire [31:0]      xfer_addr   = FRAME_BASE + 32'({xfer_idx, 2'b00});
  wire             xfer_full   = (xfer_cnt == xfer_target);

  // Lazy push waits for a running divide so the frame holds its result
  wire stack_issue = in_xfer & ~mem_busy & ~wbuf_valid & ~xfer_full &
                     ~((state == LAZY_PUSH) & div_busy);
  wire drain_issue = wbuf_valid & ~mem_busy;
  wire xfer_end    = in_xfer & xfer_full & ~mem_busy;
  // Stacking ends on words pushed and on the minimum cycle count
  wire stack_done  = (state == STACKING) & xfer_end & (stk_cyc == STACK_LAST);

  // Return proceeds only with the buffer empty
  // and with no divide able to be overwritten by FP unstacking
  wire ret_ready   = ~wbuf_valid & ~mem_busy & ~(fp_in_frame & div_busy);
  wire take_irq    = any_pend & ((state == THREAD) | ((state == RETURNING) & ret_ready));
  wire tail_chain  = (state == RETURNING) & (next_state == STACKING);

  // Set wins over the acknowledge clear; a held level pends again
  wire [NUM_IRQ-1:0] clr_mask     = take_irq ? (NUM_IRQ'(1) << top_num) : '0;
  wire [NUM_IRQ-1:0] next_pending = (pending & ~clr_mask) | irq_src_in;

  wire store_take      = store_valid_in & store_ready_out;
  wire next_wbuf_valid = store_take | (wbuf_valid & ~(mem_done & mem_is_store));
  wire next_stall      = ~((next_state == THREAD) | (next_state == HANDLER)) |
                         (next_wbuf_valid & (wbuf_dis | barrier_in));

  // Register slave decode
  wire avs_acc    = (avs_read_in | avs_write_in) & avs_waitrequest_out;
  wire wr_take    = avs_write_in & ~avs_waitrequest_out;
  wire fp_ctx_wr  = wr_take & (reg_decode(avs_address_in) == RSEL_FP_CTX) &
                    avs_byteenable_in[LAZY_SAVE_BIT / 8];
  wire aux_wr     = wr_take & (reg_decode(avs_address_in) == RSEL_AUX) &
                    avs_byteenable_in[WBUF_DIS_BIT / 8];
  wire reg_sel_t rd_sel = reg_decode(avs_address_in);
  wire [31:0] fp_ctx_word = (32'(fp_lazy_save_enable) << LAZY_SAVE_BIT) | (32'(lazy_pend) << LAZY_PEND_BIT);
  wire [31:0] aux_word    = 32'(wbuf_dis) << WBUF_DIS_BIT;
  wire [31:0] stat_word   = (32'(wbuf_valid) << STAT_WBUF_BIT) | (32'(div_busy) << STAT_DIV_BIT) |
                            (32'(lazy_pend) << STAT_LAZY_BIT) | (32'(ack_num_out) << STAT_NUM_LSB) |
                            (32'(state) << STAT_STATE_LSB);
  wire [31:0] rd_word     = (rd_sel == RSEL_FP_CTX) ? fp_ctx_word :
                            (rd_sel == RSEL_AUX)    ? aux_word :
                            (rd_sel == RSEL_STATUS) ? stat_word : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    next_state = state;
    unique case (state)
      THREAD:
        if (take_irq)
          next_state = STACKING;
      STACKING:
        if (stack_done)
          next_state = HANDLER;
      HANDLER:
        if (exc_return_in)
          next_state = RETURNING;
        else if (fp_instr_in & lazy_pend)
          next_state = LAZY_PUSH;
      LAZY_PUSH:
        if (xfer_end)
          next_state = HANDLER;
      RETURNING:
        if (ret_ready)
          next_state = any_pend ? STACKING : UNSTACKING;
      UNSTACKING:
        if (xfer_end)
          next_state = THREAD;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      state <= THREAD;
    else
      state <= next_state;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      pending <= '0;
    else
      pending <= next_pending;
  end

  // Entry captures the lazy mode; eager mode puts FP words in the frame
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      lazy_active <= 1'b0;
      fp_in_frame <= 1'b0;
    end
    else if (take_irq & (state == THREAD))
    begin
      lazy_active <= fp_lazy_save_enable;
      fp_in_frame <= ~fp_lazy_save_enable;
    end
    else if ((state == LAZY_PUSH) & xfer_end)
      fp_in_frame <= 1'b1;
    else if ((state == UNSTACKING) & xfer_end)
    begin
      lazy_active <= 1'b0;
      fp_in_frame <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      xfer_cnt <= '0;
    else if (state != next_state)
      xfer_cnt <= tail_chain ? xfer_target : '0;
    else if (mem_done & ~mem_is_store)
      xfer_cnt <= xfer_cnt + 1'b1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in | take_irq)
      stk_cyc <= '0;
    else if ((state == STACKING) & (stk_cyc != STACK_LAST))
      stk_cyc <= stk_cyc + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt acknowledge and vector; both from one latched number

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      irq_ack_out       <= 1'b0;
      ack_num_out       <= '0;
      vector_fetch_out  <= 1'b0;
      vector_num_out    <= '0;
      handler_start_out <= 1'b0;
    end
    else
    begin
      irq_ack_out       <= take_irq;
      vector_fetch_out  <= stack_done;
      handler_start_out <= stack_done;
      if (take_irq)
        ack_num_out <= top_num;
      if (stack_done)
        vector_num_out <= ack_num_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write buffer and memory master

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      wbuf_valid      <= 1'b0;
      store_ready_out <= 1'b0;
      core_stall_out  <= 1'b0;
    end
    else
    begin
      wbuf_valid      <= next_wbuf_valid;
      store_ready_out <= ~next_wbuf_valid;
      core_stall_out  <= next_stall;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (store_take)
    begin
      wbuf_addr <= store_addr_in;
      wbuf_data <= store_data_in;
    end
  end

  // Stacking words hold until the memory drops its stall
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      mem_write_out <= 1'b0;
      mem_read_out  <= 1'b0;
      mem_is_store  <= 1'b0;
      mem_addr_out  <= '0;
      mem_wdata_out <= '0;
    end
    else if (drain_issue)
    begin
      mem_write_out <= 1'b1;
      mem_is_store  <= 1'b1;
      mem_addr_out  <= wbuf_addr;
      mem_wdata_out <= wbuf_data;
    end
    else if (stack_issue)
    begin
      mem_write_out <= (state != UNSTACKING);
      mem_read_out  <= (state == UNSTACKING);
      mem_is_store  <= 1'b0;
      mem_addr_out  <= xfer_addr;
      mem_wdata_out <= 32'(xfer_idx);
    end
    else if (mem_done)
    begin
      mem_write_out <= 1'b0;
      mem_read_out  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register slave

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      fp_lazy_save_enable <= LAZY_SAVE_RESET;
      wbuf_dis <= WBUF_DIS_RESET;
    end
    else
    begin
      if (fp_ctx_wr)
        fp_lazy_save_enable <= avs_writedata_in[LAZY_SAVE_BIT];
      if (aux_wr)
        wbuf_dis <= avs_writedata_in[WBUF_DIS_BIT];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= '0;
    end
    else
    begin
      avs_waitrequest_out <= ~avs_acc;
      if (avs_acc)
        avs_readdata_out <= avs_read_in ? rd_word : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divide unit

  fp_div_unit div_unit (
    .mclk_in         (mclk_in),
    .nrst_in         (nrst_in),
    .issue_in        (div_issue_in),
    .dest_in         (div_dest_in),
    .result_in       (div_result_in),
    .flags_in        (div_flags_in),
    .busy_out        (div_busy),
    .rf_we_out       (rf_we_out),
    .rf_waddr_out    (rf_waddr_out),
    .rf_wdata_out    (rf_wdata_out),
    .fp_status_control_reg_we_out    (fp_status_control_reg_we_out),
    .fp_status_control_reg_flags_out (fp_status_control_reg_flags_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      ack_age <= AGE_MAX;
    else if (irq_ack_out)
      ack_age <= 5'h01;
    else if (ack_age != AGE_MAX)
      ack_age <= ack_age + 1'b1;
  end

  a_stack_min_time:
  assert property (@(posedge mclk_in) disable iff (!nrst_in)
    handler_start_out |-> (ack_age >= STACK_MIN))
    else $error("handler started before twelve stacking cycles");

  a_ack_vector_match:
  assert property (@(posedge mclk_in) disable iff (!nrst_in)
    vector_fetch_out |-> (vector_num_out == ack_num_out))
    else $error("vector differs from acknowledged interrupt");

  a_lazy_trigger:
  assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == HANDLER && fp_instr_in && lazy_pend && !exc_return_in) |=> (state == LAZY_PUSH))
    else $error("first FP instruction did not start lazy push");

  a_lazy_reset_on:
  assert property (@(posedge mclk_in) disable iff (!nrst_in)
    $past(!nrst_in) |-> fp_lazy_save_enable)
    else $error("lazy saving not active after reset");

  a_eager_frame:
  assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == STACKING && !lazy_active) |-> fp_in_frame)
    else $error("eager entry left FP context out of frame");

  a_return_drained:
  assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == RETURNING && next_state != RETURNING) |-> !wbuf_valid)
    else $error("return overlapped a buffered store");

  a_level_repend:
  assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (|irq_src_in) |=> ((pending & $past(irq_src_in)) == $past(irq_src_in)))
    else $error("asserted source not pending");

  a_wbuf_off_stall:
  assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (wbuf_valid && wbuf_dis && $stable(wbuf_dis)) |-> core_stall_out)
    else $error("core ran ahead of store with buffer disabled");

  a_div_return_hold:
  assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == RETURNING && fp_in_frame && div_busy) |=> (state == RETURNING))
    else $error("FP unstack could overwrite divide result");

  a_ack_single:
  assert property (@(posedge mclk_in) disable iff (!nrst_in)
    irq_ack_out |=> !irq_ack_out)
    else $error("acknowledge lasted more than one cycle");

endmodule

// ### common/fp_exc_pkg.sv
// Constants, register map and state codes of the FP exception unit.
// Assumes a single 10 MHz core clock and a synchronous active-low reset.
//
// Summary of operation
// - Divide and square root take fourteen cycles
// - Divide keeps running through exception entry
// - Lazy entry reserves FP space, pushes later
// - Lazy saving active straight after reset
// - At least twelve stacking cycles before handler
// - In-flight divide result always written back
// - Stack wait states stretch stacking safely
// - Clearing lazy enable stacks FP eagerly from the next entry from thread
// - Write buffer lets execution pass pending stores
// - Acknowledged number always equals fetched vector
// - Newer lower-numbered interrupt first, each once
// - Write buffer disable removes vector hazard
// - Asserted level source pends again
package fp_exc_pkg;

  localparam logic [31:0] FP_CTX_CTRL_ADDR = 32'hE000_EF34;
  localparam logic [31:0] AUX_CTRL_ADDR    = 32'hE000_E008;
  localparam logic [31:0] EXC_STATUS_ADDR  = 32'hE000_EF50;

  localparam int LAZY_SAVE_BIT  = 30;
  localparam int LAZY_PEND_BIT  = 0;
  localparam int WBUF_DIS_BIT   = 1;
  localparam int STAT_WBUF_BIT  = 0;
  localparam int STAT_DIV_BIT   = 1;
  localparam int STAT_LAZY_BIT  = 2;
  localparam int STAT_NUM_LSB   = 4;
  localparam int STAT_STATE_LSB = 8;

  localparam logic LAZY_SAVE_RESET = 1'b1;
  localparam logic WBUF_DIS_RESET  = 1'b0;

  localparam int DIV_CYCLES       = 14;
  localparam int STACK_MIN_CYCLES = 12;
  localparam int NUM_IRQ          = 8;
  localparam int IRQ_W            = 3;
  localparam int CNT_W            = 5;
  localparam int DIV_CNT_W        = 4;
  localparam int REG_IDX_W        = 5;
  localparam int FLAG_W           = 5;

  localparam logic [CNT_W-1:0] CORE_WORDS = 5'h08;
  localparam logic [CNT_W-1:0] FP_WORDS   = 5'h11;
  localparam logic [CNT_W-1:0] ALL_WORDS  = CORE_WORDS + FP_WORDS;
  localparam logic [CNT_W-1:0] STACK_MIN  = CNT_W'(STACK_MIN_CYCLES);
  localparam logic [CNT_W-1:0] STACK_LAST = CNT_W'(STACK_MIN_CYCLES - 1);
  localparam logic [CNT_W-1:0] AGE_MAX    = 5'h1F;

  localparam logic [31:0] STACK_TOP  = 32'h2000_8000;
  localparam logic [31:0] FRAME_BASE = STACK_TOP - 32'({ALL_WORDS, 2'b00});

  typedef enum logic [1:0] {
    RSEL_NONE   = 2'h0,
    RSEL_FP_CTX = 2'h1,
    RSEL_AUX    = 2'h2,
    RSEL_STATUS = 2'h3
  } reg_sel_t;

  typedef enum logic [5:0] {
    THREAD     = 6'h01,
    STACKING   = 6'h02,
    HANDLER    = 6'h04,
    LAZY_PUSH  = 6'h08,
    RETURNING  = 6'h10,
    UNSTACKING = 6'h20
  } exc_state_t;

endpackage

// ### verilog/fp_div_unit.sv
// Iterative divide / square-root sequencer with register write-back.
// Assumes the datapath holds the numeric result on result_in at completion.
`timescale 1ns/1ps

module fp_div_unit
  import fp_exc_pkg::*;
(
  input  wire logic                 mclk_in,      // Core clock
  input  wire logic                 nrst_in,      // Sync reset, active low
  input  wire logic                 issue_in,     // Divide or root issued
  input  wire logic [REG_IDX_W-1:0] dest_in,      // Destination register
  input  wire logic [31:0]          result_in,    // Datapath result
  input  wire logic [FLAG_W-1:0]    flags_in,     // Datapath status flags
  output logic                      busy_out,     // Operation in flight
  output logic                      rf_we_out,    // Register write strobe
  output logic [REG_IDX_W-1:0]      rf_waddr_out, // Register write index
  output logic [31:0]               rf_wdata_out, // Register write data
  output logic                      fp_status_control_reg_we_out, // Status flag strobe
  output logic [FLAG_W-1:0]         fp_status_control_reg_flags_out // Status flags
);

  localparam logic [DIV_CNT_W-1:0] DIV_LAST = DIV_CNT_W'(DIV_CYCLES - 2);

  logic [DIV_CNT_W-1:0] cnt;
  logic [REG_IDX_W-1:0] dest;

  wire start  = issue_in & ~busy_out;
  wire finish = busy_out & (cnt == DIV_LAST);

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      busy_out <= 1'b0;
      cnt      <= '0;
      dest     <= '0;
    end
    else if (start)
    begin
      busy_out <= 1'b1;
      cnt      <= '0;
      dest     <= dest_in;
    end
    else if (finish)
      busy_out <= 1'b0;
    else if (busy_out)
      cnt <= cnt + 1'b1; // Nothing aborts a running operation
  end

  // Write-back is unconditional, whatever the exception state
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      rf_we_out       <= 1'b0;
      fp_status_control_reg_we_out    <= 1'b0;
      rf_waddr_out    <= '0;
      rf_wdata_out    <= '0;
      fp_status_control_reg_flags_out <= '0;
    end
    else
    begin
      rf_we_out    <= finish;
      fp_status_control_reg_we_out <= finish;
      if (finish)
      begin
        rf_waddr_out    <= dest;
        rf_wdata_out    <= result_in;
        fp_status_control_reg_flags_out <= flags_in;
      end
    end
  end

  a_div_latency:
  assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (issue_in && !busy_out) |-> ##14 (rf_we_out && fp_status_control_reg_we_out))
    else $error("divide did not complete in fourteen cycles");

  a_div_no_abort:
  assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (busy_out && cnt != DIV_LAST) |=> busy_out)
    else $error("divide left busy before completion");

endmodule

// ### verification/fp_mem_model.sv
// Stack and store memory seen by the exception unit.
// Assumes requests are held until the stall is seen low.
`timescale 1ns/1ps

module fp_mem_model
(
  input  wire logic mclk_in,  // Core clock
  input  wire logic nrst_in,  // Sync reset, active low
  input  wire logic wr_in,    // Write request
  input  wire logic rd_in,    // Read request
  input  wire logic slow_in,  // Insert wait states
  output logic      wait_out, // Stall
  output int        n_wr_out  // Writes accepted
);
  int   cnt;
  logic done;

  assign done = cnt >= (slow_in ? 3 : 0);

  ////////////////////////////////////////////////////////////
  // Slow mode stretches every stack word
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      cnt      <= 0;
      wait_out <= 1'b1;
      n_wr_out <= 0;
    end
    else if ((wr_in || rd_in) && wait_out)
    begin
      cnt      <= done ? 0 : cnt + 1;
      wait_out <= !done;
      n_wr_out <= n_wr_out + 32'(done && wr_in);
    end
    else
      wait_out <= 1'b1;
  end
endmodule

// ### verification/tb_fp_lazy_stacking_exception_unit.sv
// Self-checking bench for the FP exception unit.
// Assumes the memory model answers the stack port.
`timescale 1ns/1ps

module tb_fp_lazy_stacking_exception_unit;
  import fp_exc_pkg::*;
  logic mclk_in = 0, nrst_in = 0, avs_read_in = 0, avs_write_in = 0, slow = 0;
  logic fp_instr_in = 0, exc_return_in = 0, barrier_in = 0, store_valid_in = 0, div_issue_in = 0;
  logic [31:0] avs_address_in = 0, avs_writedata_in = 0, store_addr_in = 32'h2000_0000;
  logic [31:0] store_data_in = 32'h0000_00A5, div_result_in = 0, q, wd = 0;
  logic [31:0] avs_readdata_out, rf_wdata_out, mem_addr_out, mem_wdata_out;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [NUM_IRQ-1:0] irq_src_in = 0;
  logic [IRQ_W-1:0] ack_num_out, vector_num_out;
  logic [REG_IDX_W-1:0] div_dest_in = 5'h03, rf_waddr_out, seen = 0;
  logic [FLAG_W-1:0] div_flags_in = 5'h01, fp_status_control_reg_flags_out;
  logic avs_waitrequest_out, irq_ack_out, vector_fetch_out, handler_start_out, core_stall_out;
  logic store_ready_out, rf_we_out, fp_status_control_reg_we_out, mem_write_out, mem_read_out, mem_waitrequest_in;
  int n_mismatch = 0, checks = 0, cyc = 0, n, w0, n_wr;
  logic [31:0] rows [5][3] = '{'{FP_CTX_CTRL_ADDR, 32'h0000_0000, 32'h0000_0000},
    '{FP_CTX_CTRL_ADDR, 32'hFFFF_FFFF, 32'h4000_0000}, '{32'hE000_0000, 32'hFFFF_FFFF, 32'h0000_0000},
    '{AUX_CTRL_ADDR, 32'hFFFF_FFFF, 32'h0000_0002}, '{AUX_CTRL_ADDR, 32'h0000_0000, 32'h0000_0000}};

  fp_lazy_stacking_exception_unit DUT (.mclk_in, .nrst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .irq_src_in,
    .irq_ack_out, .ack_num_out, .vector_fetch_out, .vector_num_out, .handler_start_out, .core_stall_out,
    .fp_instr_in, .exc_return_in, .barrier_in, .store_valid_in, .store_addr_in, .store_data_in,
    .store_ready_out, .div_issue_in, .div_dest_in, .div_result_in, .div_flags_in, .rf_we_out,
    .rf_waddr_out, .rf_wdata_out, .fp_status_control_reg_we_out, .fp_status_control_reg_flags_out, .mem_write_out, .mem_read_out,
    .mem_addr_out, .mem_wdata_out, .mem_waitrequest_in);
  fp_mem_model mem (.mclk_in(mclk_in), .nrst_in(nrst_in), .wr_in(mem_write_out), .rd_in(mem_read_out),
    .slow_in(slow), .wait_out(mem_waitrequest_in), .n_wr_out(n_wr));

  always #50 mclk_in = ~mclk_in;

  always @(posedge mclk_in)
  begin
    cyc++;
    if (rf_we_out === 1'b1)
    begin
      seen <= rf_waddr_out;
      wd   <= rf_wdata_out;
    end
    if (cyc == 5000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////
  task complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, s);
    checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask

  task bus(input logic w, input logic [31:0] a, d);
    @(posedge mclk_in);
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 0;
    avs_write_in <= 0;
  endtask

  task wait_start();
    for (n = 0; irq_ack_out !== 1'b1; n++) @(posedge mclk_in);
    for (n = 0; handler_start_out !== 1'b1; n++) @(posedge mclk_in);
    chk("vector", 32'(ack_num_out), 32'(vector_num_out));
  endtask

  task ret();
    exc_return_in <= 1;
    @(posedge mclk_in);
    exc_return_in <= 0;
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge mclk_in);
    chk("wait_rst", 1, avs_waitrequest_out);
    nrst_in <= 1;
    bus(0, FP_CTX_CTRL_ADDR, 0);
    chk("lazy_rst", 32'h4000_0000, q);
    foreach (rows[i])
    begin
      bus(1, rows[i][0], rows[i][1]);
      bus(0, rows[i][0], 0);
      chk("reg_row", rows[i][2], q);
    end
    // Store with write buffer disabled stalls the core, then drains
    bus(1, AUX_CTRL_ADDR, 32'h0000_0002);
    store_valid_in <= 1;
    @(posedge mclk_in);
    store_valid_in <= 0;
    @(posedge mclk_in);
    chk("stall_wbuf_off", 1, core_stall_out);
    @(posedge mclk_in);
    chk("drain_addr", 32'h2000_0000, mem_addr_out);
    bus(1, AUX_CTRL_ADDR, 0);
    // Lazy entry with a divide in flight
    w0 = n_wr;
    div_result_in <= 32'h1234_5678;
    div_issue_in <= 1;
    irq_src_in <= 8'h04;
    @(posedge mclk_in);
    div_issue_in <= 0;
    irq_src_in <= 0;
    wait_start();
    chk("stack_gap", 1, n >= 12);
    chk("lazy_words", 8, n_wr - w0);
    fp_instr_in <= 1;
    for (n = 0; n < 200 && n_wr - w0 < 25; n++) @(posedge mclk_in);
    fp_instr_in <= 0;
    chk("fp_push", 25, n_wr - w0);
    repeat (3) @(posedge mclk_in);
    ret();
    repeat (80) @(posedge mclk_in);
    chk("div_dest", 3, seen);
    chk("div_data", 32'h1234_5678, wd);
    // Eager entry in slow memory, then a store across return
    bus(1, FP_CTX_CTRL_ADDR, 0);
    slow <= 1;
    w0 = n_wr;
    irq_src_in <= 8'h02;
    @(posedge mclk_in);
    irq_src_in <= 8'h20;
    @(posedge mclk_in);
    irq_src_in <= 0;
    wait_start();
    chk("eager_words", 25, n_wr - w0);
    store_valid_in <= 1;
    @(posedge mclk_in);
    store_valid_in <= 0;
    irq_src_in <= 8'h08;
    ret();
    irq_src_in <= 0;
    wait_start();
    chk("tail_first", 3, 32'(ack_num_out));
    ret();
    wait_start();
    chk("tail_second", 5, 32'(ack_num_out));
    complete_run();
  end
endmodule
